// file: core/dcf_cfg.svh
// constants for the dual-sided fifo with programmable flags
`ifndef DCF_CFG_SVH
`define DCF_CFG_SVH
// ----------------------------------------
// geometry
// ----------------------------------------
`define DCF_WIDTH       18
`define DCF_AW          10
`define DCF_PW          11
`define DCF_OFF_W       12
`define DCF_DEPTH_CNT   11'h0400
`define DCF_HALF_CNT    ((`DCF_DEPTH_CNT >> 1) + 11'h0001)
// ----------------------------------------
// reset values of the threshold registers
// ----------------------------------------
`define DCF_OFF_DEFAULT ((`DCF_DEPTH_CNT == 11'h0200) ? 12'h003F : 12'h007F)
`endif

// file: core/dcf_pkg.sv
// types shared by the fifo files
package dcf_pkg;
   typedef enum logic {DCF_SEL_EMPTY, DCF_SEL_FULL} dcf_sel_t;
   typedef logic [17:0] dcf_word_t;
endpackage

// file: core/dcf_mem.sv
// storage array of the fifo, one write port and one read port
`timescale 1ns/100ps
`include "dcf_cfg.svh"
module dcf_mem (
   input  wire logic                  clk,
   input  wire logic                  wr_en,
   input  wire logic [`DCF_AW-1:0]    wr_addr,
   input  wire dcf_pkg::dcf_word_t    wr_data,
   input  wire logic [`DCF_AW-1:0]    rd_addr,
   output dcf_pkg::dcf_word_t         rd_data
);
   dcf_pkg::dcf_word_t mem [0:(1<<`DCF_AW)-1];

   // write one word per accepted write
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // read port looks straight at the array
   assign rd_data = mem[rd_addr];
endmodule

// file: core/dcf_offset_regs.sv
// the two threshold registers with their alternating load and read order
`timescale 1ns/100ps
`include "dcf_cfg.svh"
module dcf_offset_regs (
   input  wire logic                   clk,
   input  wire logic                   clear,
   input  wire logic                   load,
   input  wire logic [`DCF_OFF_W-1:0]  load_data,
   input  wire logic                   rd_step,
   output logic      [`DCF_OFF_W-1:0]  empty_off,
   output logic      [`DCF_OFF_W-1:0]  full_off,
   output logic      [`DCF_OFF_W-1:0]  rd_word
);
   dcf_pkg::dcf_sel_t wr_sel_r;
   dcf_pkg::dcf_sel_t rd_sel_r;

   // load the selected threshold, defaults on clear
   always_ff @(posedge clk) begin
      if (clear) begin
         empty_off <= `DCF_OFF_DEFAULT;
         full_off  <= `DCF_OFF_DEFAULT;
      end else if (load) begin
         if (wr_sel_r == dcf_pkg::DCF_SEL_EMPTY) begin
            empty_off <= load_data;
         end else begin
            full_off <= load_data;
         end
      end
   end

   // write order alternates and survives a pause
   always_ff @(posedge clk) begin
      if (clear) begin
         wr_sel_r <= dcf_pkg::DCF_SEL_EMPTY;
      end else if (load) begin
         wr_sel_r <= (wr_sel_r == dcf_pkg::DCF_SEL_EMPTY) ? dcf_pkg::DCF_SEL_FULL
                                                         : dcf_pkg::DCF_SEL_EMPTY;
      end
   end

   // read order alternates the same way
   always_ff @(posedge clk) begin
      if (clear) begin
         rd_sel_r <= dcf_pkg::DCF_SEL_EMPTY;
      end else if (rd_step) begin
         rd_sel_r <= (rd_sel_r == dcf_pkg::DCF_SEL_EMPTY) ? dcf_pkg::DCF_SEL_FULL
                                                         : dcf_pkg::DCF_SEL_EMPTY;
      end
   end

   assign rd_word = (rd_sel_r == dcf_pkg::DCF_SEL_EMPTY) ? empty_off : full_off;
endmodule

// file: core/dcf_fifo.sv
// top of the fifo with programmable almost-empty and almost-full flags
//
// What this block does
// - write strobe low captures word each write tick
// - read strobe and drive low present next word
// - drive control high floats outputs, low drives
// - only read-selected device drives the shared outputs
// - ignore writes when full, reads when empty
// - empty keeps last valid read word showing
// - two 12-bit thresholds loaded from low bits
// - access control low loads thresholds alternately
// - paused loading resumes with next threshold
// - threshold reads follow same alternating order
// - write decode: threshold, buffer, or nothing
// - full indicator low when full, write ticks
// - empty indicator low when empty, read ticks
// - near flags low within their threshold distance
// - 512 depth: half at 257, full 512
// - larger depths: half just past half capacity
// - thresholds default 63 or 127 by depth
// - sync select low: near flags on ticks
// - replay pulse returns read pointer to start
// - after replay reads repeat data, flags follow
// - clear returns device to empty condition
`timescale 1ns/100ps
`include "dcf_cfg.svh"
module dcf_fifo (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  write_tick,
   input  wire logic                  write_en_n,
   input  wire dcf_pkg::dcf_word_t    din,
   input  wire logic                  read_tick,
   input  wire logic                  read_en_n,
   input  wire logic                  offset_access_n,
   input  wire logic                  output_drive_n,
   input  wire logic                  read_select,
   input  wire logic                  flag_sync_select,
   input  wire logic                  replay_pulse,
   input  wire logic                  device_clear_n,
   output dcf_pkg::dcf_word_t         q_out,
   output logic                       q_drive_n,
   output logic                       full_indicator_n,
   output logic                       empty_indicator_n,
   output logic                       near_empty_indicator_n,
   output logic                       near_full_indicator_n,
   output logic                       half_level_indicator_n
);
   // ----------------------------------------
   // decode
   // ----------------------------------------
   logic                    clear;
   logic [`DCF_PW-1:0]      wptr_r;
   logic [`DCF_PW-1:0]      rptr_r;
   logic [`DCF_PW-1:0]      wptr_nxt;
   logic [`DCF_PW-1:0]      rptr_nxt;
   logic [`DCF_PW-1:0]      count;
   logic [`DCF_PW-1:0]      count_nxt;
   logic                    is_full;
   logic                    is_empty;
   logic                    buf_write;
   logic                    off_write;
   logic                    buf_read;
   logic                    off_read;
   logic [`DCF_OFF_W-1:0]   empty_off;
   logic [`DCF_OFF_W-1:0]   full_off;
   logic [`DCF_OFF_W-1:0]   off_word;
   dcf_pkg::dcf_word_t      mem_word;
   logic                    near_empty_nxt;
   logic                    near_full_nxt;
   logic [`DCF_OFF_W:0]     full_sum;

   // either reset or the device clear empties the fifo
   assign clear = !rst_n || !device_clear_n;

   assign count    = wptr_r - rptr_r;
   assign is_full  = (count == `DCF_DEPTH_CNT);
   assign is_empty = (count == '0);

   // write side decode, full blocks whatever the strobe says
   assign off_write = write_tick && !write_en_n && !offset_access_n;
   assign buf_write = write_tick && !write_en_n && offset_access_n && !is_full;

   // read side decode, empty blocks whatever the strobe says
   assign off_read = read_tick && !read_en_n && !offset_access_n;
   assign buf_read = read_tick && !read_en_n && offset_access_n && !is_empty;

   // pointer next values, replay wins over a read
   assign wptr_nxt  = buf_write ? wptr_r + 11'h0001 : wptr_r;
   assign rptr_nxt  = replay_pulse ? '0 : (buf_read ? rptr_r + 11'h0001 : rptr_r);
   assign count_nxt = wptr_nxt - rptr_nxt;

   // thresholds compared with the coming word count
   assign full_sum       = {2'b00, count_nxt} + {1'b0, full_off};
   assign near_empty_nxt = ({1'b0, count_nxt} <= empty_off);
   assign near_full_nxt  = (full_sum >= {2'b00, `DCF_DEPTH_CNT});

   // ----------------------------------------
   // storage and thresholds
   // ----------------------------------------
   dcf_mem u_mem (
      .clk     (clk),
      .wr_en   (buf_write),
      .wr_addr (wptr_r[`DCF_AW-1:0]),
      .wr_data (din),
      .rd_addr (rptr_r[`DCF_AW-1:0]),
      .rd_data (mem_word)
   );

   dcf_offset_regs u_off (
      .clk       (clk),
      .clear     (clear),
      .load      (off_write),
      .load_data (din[`DCF_OFF_W-1:0]),
      .rd_step   (off_read),
      .empty_off (empty_off),
      .full_off  (full_off),
      .rd_word   (off_word)
   );

   // ----------------------------------------
   // pointers
   // ----------------------------------------
   // write pointer advances per accepted word
   always_ff @(posedge clk) begin
      if (clear) begin
         wptr_r <= '0;
      end else begin
         wptr_r <= wptr_nxt;
      end
   end

   // read pointer advances per accepted read or jumps back on replay
   always_ff @(posedge clk) begin
      if (clear) begin
         rptr_r <= '0;
      end else begin
         rptr_r <= rptr_nxt;
      end
   end

   // ----------------------------------------
   // output word and drive
   // ----------------------------------------
   // output register keeps the last valid word when nothing is read
   always_ff @(posedge clk) begin
      if (clear) begin
         q_out <= '0;
      end else if (buf_read) begin
         q_out <= mem_word;
      end else if (off_read) begin
         q_out <= {6'h00, off_word};
      end
   end

   // outputs float unless drive is low and this device is read-selected
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q_drive_n <= 1'b1;
      end else begin
         q_drive_n <= output_drive_n || !read_select;
      end
   end

   // ----------------------------------------
   // flags
   // ----------------------------------------
   // full indicator moves on write ticks only
   always_ff @(posedge clk) begin
      if (clear) begin
         full_indicator_n <= 1'b1;
      end else if (write_tick) begin
         full_indicator_n <= !(count_nxt == `DCF_DEPTH_CNT);
      end
   end

   // empty indicator moves on read ticks only
   always_ff @(posedge clk) begin
      if (clear) begin
         empty_indicator_n <= 1'b0;
      end else if (read_tick) begin
         empty_indicator_n <= !(count_nxt == '0);
      end
   end

   // near-full on write ticks in sync mode, every cycle otherwise
   always_ff @(posedge clk) begin
      if (clear) begin
         near_full_indicator_n <= 1'b1;
      end else if (write_tick || flag_sync_select) begin
         near_full_indicator_n <= !near_full_nxt;
      end
   end

   // near-empty on read ticks in sync mode, every cycle otherwise
   always_ff @(posedge clk) begin
      if (clear) begin
         near_empty_indicator_n <= 1'b0;
      end else if (read_tick || flag_sync_select) begin
         near_empty_indicator_n <= !near_empty_nxt;
      end
   end

   // half level follows the count every cycle
   always_ff @(posedge clk) begin
      if (clear) begin
         half_level_indicator_n <= 1'b1;
      end else begin
         half_level_indicator_n <= !(count_nxt >= `DCF_HALF_CNT);
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   property p_full_set;
      @(posedge clk) disable iff (clear)
      write_tick && (count_nxt == `DCF_DEPTH_CNT) |=> !full_indicator_n;
   endproperty
   a_full_set: assert property (p_full_set) else $error("full flag not set");

   property p_full_hold;
      @(posedge clk) disable iff (clear)
      !write_tick |=> $stable(full_indicator_n);
   endproperty
   a_full_hold: assert property (p_full_hold) else $error("full moved off tick");

   property p_empty_hold;
      @(posedge clk) disable iff (clear)
      !read_tick |=> $stable(empty_indicator_n);
   endproperty
   a_empty_hold: assert property (p_empty_hold) else $error("empty moved off tick");

   property p_no_overrun;
      @(posedge clk) disable iff (clear)
      is_full |=> $stable(wptr_r);
   endproperty
   a_no_overrun: assert property (p_no_overrun) else $error("write into full");

   property p_keep_last;
      @(posedge clk) disable iff (clear)
      is_empty && offset_access_n |=> $stable(q_out);
   endproperty
   a_keep_last: assert property (p_keep_last) else $error("output changed empty");

   property p_float;
      @(posedge clk) disable iff (!rst_n)
      output_drive_n || !read_select |=> q_drive_n;
   endproperty
   a_float: assert property (p_float) else $error("driving while off");

   property p_replay;
      @(posedge clk) disable iff (clear)
      replay_pulse |=> (rptr_r == '0);
   endproperty
   a_replay: assert property (p_replay) else $error("replay missed");

   property p_half;
      @(posedge clk) disable iff (clear)
      (count_nxt >= `DCF_HALF_CNT) |=> !half_level_indicator_n;
   endproperty
   a_half: assert property (p_half) else $error("half flag wrong");

   property p_clear;
      @(posedge clk)
      clear |=> !empty_indicator_n && full_indicator_n && (empty_off == `DCF_OFF_DEFAULT);
   endproperty
   a_clear: assert property (p_clear) else $error("clear state wrong");

   property p_near_full;
      @(posedge clk) disable iff (clear)
      !flag_sync_select && !write_tick |=> $stable(near_full_indicator_n);
   endproperty
   a_near_full: assert property (p_near_full) else $error("near-full off tick");

   property p_empty_set;
      @(posedge clk) disable iff (clear)
      read_tick && (count_nxt == '0) |=> !empty_indicator_n;
   endproperty
   a_empty_set: assert property (p_empty_set) else $error("empty flag not set");

   property p_ne_zero;
      @(posedge clk) disable iff (clear)
      (read_tick || flag_sync_select) && (count_nxt == '0) |=> !near_empty_indicator_n;
   endproperty
   a_ne_zero: assert property (p_ne_zero) else $error("near-empty not low");

   property p_no_underrun;
      @(posedge clk) disable iff (clear)
      is_empty && !replay_pulse |=> $stable(rptr_r);
   endproperty
   a_no_underrun: assert property (p_no_underrun) else $error("read from empty");

   c_full:   cover property (@(posedge clk) disable iff (clear) !full_indicator_n);
   c_replay: cover property (@(posedge clk) disable iff (clear) replay_pulse && !is_empty);
   c_offwr:  cover property (@(posedge clk) disable iff (clear) off_write ##1 off_write);
   c_offrd:  cover property (@(posedge clk) disable iff (clear) off_read ##1 off_read);
   c_nfull:  cover property (@(posedge clk) disable iff (clear) !near_full_indicator_n);
endmodule

// file: dv/dcf_ext_ctrl.sv
// far-side writer and reader model: turns requests into write and read clock ticks
`timescale 1ns/100ps
module dcf_ext_ctrl #(
   parameter int REPLAY_RECOVERY_TIME = 2
) (
   input  wire logic clk,
   input  wire logic wr_go,
   input  wire logic rd_go,
   input  wire logic replay_pulse,
   input  wire logic device_clear_n,
   output logic      write_tick,
   output logic      read_tick
);
   logic [3:0] quiet_r = 4'h0;
   // ----------------------------------------
   // recovery count after replay or clear
   // ----------------------------------------
   always @(posedge clk) begin
      if (replay_pulse || !device_clear_n) begin
         quiet_r <= 4'(REPLAY_RECOVERY_TIME);
      end else if (quiet_r != 4'h0) begin
         quiet_r <= quiet_r - 4'h1;
      end
   end
   // both clocks stand still during replay, clear and the recovery after them
   assign write_tick = wr_go && !replay_pulse && device_clear_n && (quiet_r == 4'h0);
   assign read_tick  = rd_go && !replay_pulse && device_clear_n && (quiet_r == 4'h0);
endmodule

// file: dv/test_dcf_fifo.sv
// self-checking bench for the fifo with programmable flags
`timescale 1ns/100ps
`include "dcf_cfg.svh"
module test_dcf_fifo;
   logic               clk = 1'b0;
   logic               rst_n = 1'b0;
   logic               write_en_n = 1'b1;
   logic               read_en_n = 1'b1;
   logic               offset_access_n = 1'b1;
   logic               output_drive_n = 1'b1;
   logic               read_select = 1'b1;
   logic               replay_pulse = 1'b0;
   logic               device_clear_n = 1'b1;
   logic               wr_go = 1'b0;
   logic               rd_go = 1'b0;
   logic               flag_sync_select = 1'b0;
   logic               write_tick;
   logic               read_tick;
   dcf_pkg::dcf_word_t din = 18'h0_0000;
   dcf_pkg::dcf_word_t q_out;
   logic               q_drive_n;
   logic               full_n;
   logic               empty_n;
   logic               near_e_n;
   logic               near_f_n;
   logic               half_n;
   dcf_pkg::dcf_word_t q_hi;
   logic               full_hi_n;
   logic               empty_hi_n;
   int                 n_fail = 0;
   int                 checked = 0;

   always #12.5 clk = ~clk;

   dcf_ext_ctrl u_dcf_ext_ctrl (.clk(clk), .wr_go(wr_go), .rd_go(rd_go),
      .replay_pulse(replay_pulse), .device_clear_n(device_clear_n),
      .write_tick(write_tick), .read_tick(read_tick));

   dcf_fifo u_dcf_fifo (.clk(clk), .rst_n(rst_n), .write_tick(write_tick),
      .write_en_n(write_en_n), .din(din), .read_tick(read_tick), .read_en_n(read_en_n),
      .offset_access_n(offset_access_n), .output_drive_n(output_drive_n),
      .read_select(read_select), .flag_sync_select(flag_sync_select),
      .replay_pulse(replay_pulse),
      .device_clear_n(device_clear_n), .q_out(q_out), .q_drive_n(q_drive_n),
      .full_indicator_n(full_n), .empty_indicator_n(empty_n),
      .near_empty_indicator_n(near_e_n), .near_full_indicator_n(near_f_n),
      .half_level_indicator_n(half_n));

   // upper half of a 36-bit word: all controls shared, full and empty flags combined by and
   dcf_fifo u_dcf_fifo_hi (.clk(clk), .rst_n(rst_n), .write_tick(write_tick),
      .write_en_n(write_en_n), .din(~din), .read_tick(read_tick), .read_en_n(read_en_n),
      .offset_access_n(offset_access_n), .output_drive_n(output_drive_n),
      .read_select(read_select), .flag_sync_select(flag_sync_select),
      .replay_pulse(replay_pulse), .device_clear_n(device_clear_n), .q_out(q_hi),
      .q_drive_n(), .full_indicator_n(full_hi_n), .empty_indicator_n(empty_hi_n),
      .near_empty_indicator_n(), .near_full_indicator_n(), .half_level_indicator_n());

   // ----------------------------------------
   // access tasks, all driven at the falling edge
   // ----------------------------------------
   task automatic step(input logic w, input logic wen_n, input logic r, input logic ren_n,
                       input logic ld_n, input logic [17:0] d);
      @(negedge clk);
      wr_go = w;
      write_en_n = wen_n;
      rd_go = r;
      read_en_n = ren_n;
      offset_access_n = ld_n;
      din = d;
   endtask

   task automatic wr(input logic [17:0] d);
      step(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, d);
   endtask

   task automatic rd(input logic ld_n);
      step(1'b0, 1'b1, 1'b1, 1'b0, ld_n, 18'h0_0000);
   endtask

   task automatic idle;
      step(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 18'h0_0000);
   endtask

   task automatic chk(input string name, input logic [17:0] exp, input logic [17:0] got);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic do_reset;
      @(negedge clk);
      rst_n = 1'b0;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
   endtask

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // watchdog sized well above the roughly 1100 cycles the tests need
   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      final_report;
   end

   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial begin
      do_reset;
      chk("empty_n", 18'h0_0000, 18'(empty_n));
      chk("full_n", 18'h0_0001, 18'(full_n));
      chk("near_e_n", 18'h0_0000, 18'(near_e_n));
      chk("near_f_n", 18'h0_0001, 18'(near_f_n));
      chk("half_n", 18'h0_0001, 18'(half_n));
      rd(1'b0);
      rd(1'b0);
      chk("thr_empty", 18'h0_007F, q_out);
      idle;
      chk("thr_full", 18'h0_007F, q_out);
      $display("test reset_values done");
      // load empty, pause, refuse a high strobe, load full, load empty again
      step(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 18'h0_0005);
      idle;
      step(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 18'h0_0777);
      step(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 18'h0_0009);
      step(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 18'h3_F003);
      rd(1'b0);
      rd(1'b0);
      chk("thr_empty", 18'h0_0003, q_out);
      idle;
      chk("thr_full", 18'h0_0009, q_out);
      $display("test thresholds done");
      // four words in, flags wait for a read tick
      for (int i = 0; i < 4; i++) begin
         wr(18'h1_0000 + 18'(i));
      end
      idle;
      chk("empty_n", 18'h0_0000, 18'(empty_n));
      chk("near_e_n", 18'h0_0000, 18'(near_e_n));
      step(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 18'h0_0000);
      idle;
      chk("empty_n", 18'h0_0001, 18'(empty_n));
      chk("near_e_n", 18'h0_0001, 18'(near_e_n));
      chk("q_out", 18'h0_0009, q_out);
      for (int i = 0; i < 4; i++) begin
         rd(1'b1);
         if (i > 0) begin
            chk("q_out", 18'h1_0000 + 18'(i - 1), q_out);
         end
         if (i == 1) begin
            chk("near_e_n", 18'h0_0000, 18'(near_e_n));
         end
      end
      idle;
      chk("q_out", 18'h1_0003, q_out);
      chk("empty_n", 18'h0_0000, 18'(empty_n));
      rd(1'b1);
      idle;
      chk("q_out", 18'h1_0003, q_out);
      chk("q_hi", 18'h2_FFFC, q_hi);
      chk("wide_empty_n", 18'h0_0000, 18'(empty_n & empty_hi_n));
      $display("test data_flow done");
      // free-running near flags follow the count without a read tick
      flag_sync_select = 1'b1;
      for (int i = 0; i < 4; i++) begin
         wr(18'h0_0100 + 18'(i));
      end
      idle;
      chk("near_e_n", 18'h0_0001, 18'(near_e_n));
      chk("empty_n", 18'h0_0000, 18'(empty_n));
      flag_sync_select = 1'b0;
      $display("test async_flags done");
      // output drive control and read selection
      output_drive_n = 1'b0;
      @(negedge clk);
      chk("q_drive_n", 18'h0_0000, 18'(q_drive_n));
      read_select = 1'b0;
      @(negedge clk);
      chk("q_drive_n", 18'h0_0001, 18'(q_drive_n));
      read_select = 1'b1;
      output_drive_n = 1'b1;
      @(negedge clk);
      chk("q_drive_n", 18'h0_0001, 18'(q_drive_n));
      $display("test output_drive done");
      // fill to capacity, then replay
      do_reset;
      for (int i = 0; i < int'(`DCF_DEPTH_CNT); i++) begin
         wr(18'(i) + 18'h0_0001);
         if (i == int'(`DCF_HALF_CNT) - 1) begin
            chk("half_n", 18'h0_0001, 18'(half_n));
         end
         if (i == int'(`DCF_HALF_CNT)) begin
            chk("half_n", 18'h0_0000, 18'(half_n));
         end
         if (i == int'(`DCF_DEPTH_CNT) - 128) begin
            chk("near_f_n", 18'h0_0001, 18'(near_f_n));
         end
         if (i == int'(`DCF_DEPTH_CNT) - 127) begin
            chk("near_f_n", 18'h0_0000, 18'(near_f_n));
         end
      end
      idle;
      chk("full_n", 18'h0_0000, 18'(full_n));
      chk("wide_full_n", 18'h0_0000, 18'(full_n & full_hi_n));
      wr(18'h3_FFFF);
      rd(1'b1);
      rd(1'b1);
      idle;
      chk("q_out", 18'h0_0002, q_out);
      replay_pulse = 1'b1;
      @(negedge clk);
      replay_pulse = 1'b0;
      repeat (3) idle;
      rd(1'b1);
      rd(1'b1);
      chk("q_out", 18'h0_0001, q_out);
      idle;
      chk("q_out", 18'h0_0002, q_out);
      $display("test fill_replay done");
      // clear mid-run
      device_clear_n = 1'b0;
      @(negedge clk);
      device_clear_n = 1'b1;
      idle;
      chk("empty_n", 18'h0_0000, 18'(empty_n));
      chk("full_n", 18'h0_0001, 18'(full_n));
      chk("half_n", 18'h0_0001, 18'(half_n));
      $display("test clear done");
      final_report;
   end
endmodule
